// ### logic/laser_port_defines.svh
// Summary of operation
// - other inputs ignored unless run request high; start low clears ended and program number gates analog mode without it
// - nonzero number starts program; zero enables emission
// - alarm clear acts on rising edge
// - stop input aborts running program immediately
// - program number bit zero is first line
// - wait step holds until sync input seen
// - main power follows switch input edges
// - gate select zero closes, one-three opens channel
// - pulsed mode enable drives pulsed mode status
// - ready high exactly when able to emit
// - emitting high only while light emitted
// - internal mode output follows internal control
// - anomaly output shows abnormal condition
// - guide light output shows guide beam on
// - analog mode output shows analog power setting while program number is zero
// - acknowledge output shows run request received
// - main power output follows supply state
// - running output high during program execution
// - ended set at finish, cleared start low
// - abnormal flag cleared only by alarm clear
// - sync output pulse under program control
// - warning output shows warning condition
// - gate status output names open channel
// - coolant warning and alarm; alarm blocks emission
// - unit address presented on four lines
`ifndef LASER_PORT_DEFINES_SVH
`define LASER_PORT_DEFINES_SVH

// ==========================================================
// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_COND 8'h04
`define REG_PROG 8'h08
`define REG_ADDR 8'h0c
`define REG_STAT 8'h10

// ==========================================================
// field positions
`define CTRL_INTERNAL 0
`define CTRL_GUIDE 1
`define CTRL_ANALOG 2
`define CTRL_PERMIT 3
`define COND_ANOMALY 0
`define COND_WARNING 1
`define COND_COOL_WARN 2
`define COND_COOL_ALARM 3
`define PROG_WAIT 0
`define PROG_FINISH 1
`define PROG_ABORT 2
`define PROG_SYNC 3

// ==========================================================
// reset values
`define CTRL_RESET 4'h0
`define COND_RESET 4'h0
`define ADDR_RESET 4'h0

// ==========================================================
// timing
`define CLK_PERIOD_NS 40
`define DEBOUNCE_NS 10000
`define DEBOUNCE_CYC ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_PULSE_NS 1000
`define SYNC_PULSE_CYC (`SYNC_PULSE_NS / `CLK_PERIOD_NS)

`endif

// ### logic/laser_port_pkg.sv
package laser_port_pkg;

    // program sequencer states
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_RUN = 2'b01,
        P_WAIT = 2'b10
    } prog_state_t;

endpackage

// ### logic/input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner #(
    parameter int WIDTH = 18,
    parameter int COUNT = 250
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] clean
);
    localparam int CW = $clog2(COUNT + 1);

    // ==========================================================
    // elaboration checks
    initial begin
        if (COUNT < 1 || WIDTH < 1) begin
            $error("input_conditioner: COUNT and WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [CW-1:0] cnt_reg [WIDTH];

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (ce) begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
        end
    end

    // a level must stay different for COUNT cycles before it is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clean <= '0;
            for (int i = 0; i < WIDTH; i++) begin
                cnt_reg[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (sync2_reg[i] == clean[i]) begin
                    cnt_reg[i] <= '0;
                end else if (cnt_reg[i] == CW'(COUNT - 1)) begin
                    cnt_reg[i] <= '0;
                    clean[i] <= sync2_reg[i];
                end else begin
                    cnt_reg[i] <= cnt_reg[i] + 1'b1;
                end
            end
        end
    end
endmodule

// ### logic/laser_remote_port.sv
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "laser_port_defines.svh"
module laser_remote_port #(
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
    parameter int SYNC_CYCLES = `SYNC_PULSE_CYC,
    parameter bit GATE_SUPPORTED = 1'b1,
    parameter bit PULSED_SUPPORTED = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_request_in,
    input wire logic program_start_in,
    input wire logic alarm_clear_in,
    input wire logic program_stop_in,
    input wire logic [6:0] program_number_in,
    input wire logic sync_in,
    input wire logic main_power_switch_in,
    input wire logic [3:0] gate_channel_select_in,
    input wire logic pulsed_mode_enable_in,
    output logic ready_out,
    output logic emitting_out,
    output logic internal_mode_out,
    output logic anomaly_out,
    output logic guide_light_out,
    output logic analog_power_mode_out,
    output logic request_ack_out,
    output logic main_power_on_out,
    output logic program_running_out,
    output logic program_ended_out,
    output logic abnormal_termination_out,
    output logic sync_out,
    output logic warning_out,
    output logic [3:0] gate_channel_status_out,
    output logic coolant_warning_out,
    output logic coolant_alarm_out,
    output logic pulsed_mode_status_out,
    output logic [3:0] unit_address_out
);
    localparam int SW = $clog2(SYNC_CYCLES + 1);

    initial begin
        if (SYNC_CYCLES < 1 || DEBOUNCE_CYCLES < 1) begin
            $error("laser_remote_port: cycle counts must be at least 1");
        end
    end

    // gate codes above three name no channel and are ignored
    function automatic logic gate_code_ok(input logic [3:0] code);
        return code <= 4'h3;
    endfunction

    // ==========================================================
    // input conditioning
    logic [17:0] db;
    logic [17:0] prev_reg;
    logic [17:0] rise;
    logic [17:0] fall;

    input_conditioner #(.WIDTH(18), .COUNT(DEBOUNCE_CYCLES)) u_cond (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .raw({pulsed_mode_enable_in, gate_channel_select_in, main_power_switch_in,
              sync_in, program_number_in, program_stop_in, alarm_clear_in,
              program_start_in, run_request_in}),
        .clean(db)
    );

    logic req;
    logic start;
    logic stop;
    logic [6:0] pnum;
    logic [3:0] gsel;
    assign req = db[0];
    assign start = db[1];
    assign stop = db[3];
    assign pnum = db[10:4]; // bit 0 is the first line
    assign gsel = db[16:13];
    assign rise = db & ~prev_reg;
    assign fall = ~db & prev_reg;

    // edges are taken from the debounced levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= '0;
        end else if (ce) begin
            prev_reg <= db;
        end
    end

    // ==========================================================
    // apb slave, zero wait states
    logic [3:0] ctrl_reg;
    logic [3:0] cond_reg;
    logic [3:0] addr_reg;
    logic [31:0] rdata_next;
    logic wr_en;
    logic map_hit;
    logic cmd_wait;
    logic cmd_finish;
    logic cmd_abort;
    logic cmd_sync;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && pstrb[0] && ce;
    assign map_hit = paddr == `REG_CTRL || paddr == `REG_COND || paddr == `REG_PROG ||
                     paddr == `REG_ADDR || paddr == `REG_STAT;
    assign pslverr = psel && penable && !map_hit;
    assign cmd_wait = wr_en && paddr == `REG_PROG && pwdata[`PROG_WAIT];
    assign cmd_finish = wr_en && paddr == `REG_PROG && pwdata[`PROG_FINISH];
    assign cmd_abort = wr_en && paddr == `REG_PROG && pwdata[`PROG_ABORT];
    assign cmd_sync = wr_en && paddr == `REG_PROG && pwdata[`PROG_SYNC];

    // software-owned settings; only byte lane 0 carries bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
            cond_reg <= `COND_RESET;
            addr_reg <= `ADDR_RESET;
        end else if (wr_en) begin
            if (paddr == `REG_CTRL) begin
                ctrl_reg <= pwdata[3:0];
            end
            if (paddr == `REG_COND) begin
                cond_reg <= pwdata[3:0];
            end
            if (paddr == `REG_ADDR) begin
                addr_reg <= pwdata[3:0];
            end
        end
    end

    laser_port_pkg::prog_state_t state_reg;
    logic [6:0] prog_num_reg;

    // read data is loaded in the setup cycle so it leaves a flop
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            `REG_CTRL: rdata_next[3:0] = ctrl_reg;
            `REG_COND: rdata_next[3:0] = cond_reg;
            `REG_ADDR: rdata_next[3:0] = addr_reg;
            `REG_STAT: rdata_next[20:0] = {prog_num_reg, gate_channel_status_out,
                                           state_reg, pulsed_mode_status_out,
                                           sync_out, abnormal_termination_out,
                                           program_ended_out, main_power_on_out,
                                           emitting_out, ready_out, request_ack_out};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= rdata_next;
        end
    end

    // ==========================================================
    // program sequencer
    logic ready_w;
    logic abort_ev;
    logic finish_ev;
    logic start_ok;

    // every port command except start low, which clears the ended flag, and the program number, which gates analog mode, is gated by the run request
    assign ready_w = main_power_on_out && ctrl_reg[`CTRL_PERMIT] &&
                     !cond_reg[`COND_ANOMALY] && !cond_reg[`COND_COOL_ALARM];
    assign start_ok = req && rise[1] && pnum != 7'h00 && !stop && ready_w;
    // dropping request, start or readiness mid-program is treated as an abort
    assign abort_ev = state_reg != laser_port_pkg::P_IDLE &&
                      ((req && stop) || cmd_abort || !req || !start || !ready_w);
    assign finish_ev = state_reg == laser_port_pkg::P_RUN && !abort_ev && cmd_finish;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= laser_port_pkg::P_IDLE;
            prog_num_reg <= 7'h00;
        end else if (ce) begin
            unique case (state_reg)
                laser_port_pkg::P_IDLE: begin
                    if (start_ok) begin
                        prog_num_reg <= pnum; // captured at the start edge
                        state_reg <= laser_port_pkg::P_RUN;
                    end
                end
                laser_port_pkg::P_RUN: begin
                    if (abort_ev || finish_ev) begin
                        state_reg <= laser_port_pkg::P_IDLE;
                    end else if (cmd_wait) begin
                        state_reg <= laser_port_pkg::P_WAIT;
                    end
                end
                laser_port_pkg::P_WAIT: begin
                    if (abort_ev) begin
                        state_reg <= laser_port_pkg::P_IDLE;
                    end else if (req && rise[11]) begin
                        state_reg <= laser_port_pkg::P_RUN;
                    end
                end
                default: state_reg <= laser_port_pkg::P_IDLE;
            endcase
        end
    end

    // ended and abnormal flags; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_ended_out <= 1'b0;
            abnormal_termination_out <= 1'b0;
        end else if (ce) begin
            if (finish_ev) begin
                program_ended_out <= 1'b1;
            end else if (!start) begin
                program_ended_out <= 1'b0;
            end
            if (abort_ev) begin
                abnormal_termination_out <= 1'b1;
            end else if (req && rise[2]) begin
                abnormal_termination_out <= 1'b0;
            end
        end
    end

    // sync output pulse, started only in the run state; it runs its full length even if the program then ends
    logic [SW-1:0] sync_cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt_reg <= '0;
            sync_out <= 1'b0;
        end else if (ce) begin
            if (cmd_sync && state_reg == laser_port_pkg::P_RUN) begin
                sync_cnt_reg <= SW'(SYNC_CYCLES);
                sync_out <= 1'b1;
            end else if (sync_cnt_reg > SW'(1)) begin
                sync_cnt_reg <= sync_cnt_reg - 1'b1;
            end else begin
                sync_cnt_reg <= '0;
                sync_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // port-driven state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_power_on_out <= 1'b0;
            gate_channel_status_out <= 4'h0;
            pulsed_mode_status_out <= 1'b0;
            request_ack_out <= 1'b0;
        end else if (ce) begin
            if (req && rise[12]) begin
                main_power_on_out <= 1'b1;
            end else if (req && fall[12]) begin
                main_power_on_out <= 1'b0;
            end
            if (GATE_SUPPORTED && req && gate_code_ok(gsel)) begin
                gate_channel_status_out <= gsel;
            end
            pulsed_mode_status_out <= PULSED_SUPPORTED && req && db[17];
            request_ack_out <= req;
        end
    end

    // status outputs; coolant alarm forbids emission
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_out <= 1'b0;
            emitting_out <= 1'b0;
            internal_mode_out <= 1'b0;
            anomaly_out <= 1'b0;
            guide_light_out <= 1'b0;
            analog_power_mode_out <= 1'b0;
            warning_out <= 1'b0;
            coolant_warning_out <= 1'b0;
            coolant_alarm_out <= 1'b0;
            unit_address_out <= 4'h0;
        end else if (ce) begin
            ready_out <= ready_w;
            emitting_out <= ready_w && req && start &&
                            (state_reg != laser_port_pkg::P_IDLE || pnum == 7'h00);
            internal_mode_out <= ctrl_reg[`CTRL_INTERNAL];
            anomaly_out <= cond_reg[`COND_ANOMALY];
            guide_light_out <= ctrl_reg[`CTRL_GUIDE];
            analog_power_mode_out <= ctrl_reg[`CTRL_ANALOG] && pnum == 7'h00;
            warning_out <= cond_reg[`COND_WARNING];
            coolant_warning_out <= cond_reg[`COND_COOL_WARN];
            coolant_alarm_out <= cond_reg[`COND_COOL_ALARM];
            unit_address_out <= addr_reg;
        end
    end

    assign program_running_out = state_reg != laser_port_pkg::P_IDLE;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ignore;
        !req && ce ##0 rise[12] |=> $stable(main_power_on_out);
    endproperty
    a_ignore: assert property (p_ignore) else $error("power changed without request");

    property p_start;
        ce && state_reg == laser_port_pkg::P_IDLE && start_ok |=> program_running_out;
    endproperty
    a_start: assert property (p_start) else $error("program did not start");

    property p_stop;
        ce && program_running_out && req && stop
            |=> !program_running_out && abnormal_termination_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");

    property p_wait;
        ce && state_reg == laser_port_pkg::P_WAIT && !abort_ev && !(req && rise[11])
            |=> state_reg == laser_port_pkg::P_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("wait step left without sync");

    property p_power;
        ce && req && rise[12] |=> main_power_on_out;
    endproperty
    a_power: assert property (p_power) else $error("power edge not taken");

    property p_gate;
        ce && req && GATE_SUPPORTED && gsel == 4'h2 |=> gate_channel_status_out == 4'h2;
    endproperty
    a_gate: assert property (p_gate) else $error("gate channel not reported");

    property p_ended;
        ce && !start && !finish_ev |=> !program_ended_out;
    endproperty
    a_ended: assert property (p_ended) else $error("ended flag not cleared");

    property p_abn;
        ce && abnormal_termination_out && !(req && rise[2]) |=> abnormal_termination_out;
    endproperty
    a_abn: assert property (p_abn) else $error("abnormal flag lost");

    property p_cool;
        coolant_alarm_out |-> !emitting_out;
    endproperty
    a_cool: assert property (p_cool) else $error("emission during coolant alarm");

    property p_ack;
        ce && req ##1 ce |-> request_ack_out;
    endproperty
    a_ack: assert property (p_ack) else $error("request not acknowledged");

    c_finish: cover property (finish_ev ##1 program_ended_out);
    c_waitsync: cover property (state_reg == laser_port_pkg::P_WAIT ##[1:50] program_running_out
                                && state_reg == laser_port_pkg::P_RUN);
    c_abort: cover property (abort_ev ##1 abnormal_termination_out);
    c_emit: cover property (emitting_out && state_reg == laser_port_pkg::P_IDLE);
endmodule

// ### bench/machine_controller_model.sv
`timescale 1ns/1ps
// ==========================================================
// external machine controller driving the discrete port lines
module machine_controller_model #(
    parameter int SETTLE = 10,
    parameter int CLEAR_HOLD = 25000
) (
    input wire logic pclk,
    input wire logic program_running_out,
    output logic run_request_in,
    output logic program_start_in,
    output logic alarm_clear_in,
    output logic program_stop_in,
    output logic [6:0] program_number_in,
    output logic sync_in,
    output logic main_power_switch_in,
    output logic [3:0] gate_channel_select_in,
    output logic pulsed_mode_enable_in
);
    // every line idle low from time zero
    initial begin
        {run_request_in, program_start_in, alarm_clear_in, program_stop_in} = 4'h0;
        {sync_in, main_power_switch_in, pulsed_mode_enable_in} = 3'h0;
        program_number_in = 7'h00;
        gate_channel_select_in = 4'h0;
    end

    // one line changes just after an edge, then the debounce is given time to settle
    task set_line(input int which, input int v);
        int n;
        n = 0;
        // start may only fall once the running flag has gone; bounded so a hang shows
        while (which == 1 && v == 0 && program_running_out !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        case (which)
            0: run_request_in <= v[0];
            1: program_start_in <= v[0];
            2: alarm_clear_in <= v[0];
            3: program_stop_in <= v[0];
            4: program_number_in <= v[6:0];
            5: sync_in <= v[0];
            6: main_power_switch_in <= v[0];
            7: gate_channel_select_in <= v[3:0];
            default: pulsed_mode_enable_in <= v[0];
        endcase
        // clear pulse kept high for a full millisecond
        if (which == 2 && v == 1) repeat (CLEAR_HOLD) @(posedge pclk);
        repeat (SETTLE) @(posedge pclk);
    endtask
endmodule

// ### bench/laser_hardwired_remote_control_port_bench.sv
`timescale 1ns/1ps
// ==========================================================
// bench top: apb master, line model and expected-state model
module laser_hardwired_remote_control_port_bench;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic run_request_in, program_start_in, alarm_clear_in, program_stop_in, sync_in;
    logic main_power_switch_in, pulsed_mode_enable_in;
    logic [6:0] program_number_in, num;
    logic [3:0] gate_channel_select_in, gate_channel_status_out, unit_address_out;
    logic ready_out, emitting_out, internal_mode_out, anomaly_out, guide_light_out;
    logic analog_power_mode_out, request_ack_out, main_power_on_out, program_running_out;
    logic program_ended_out, abnormal_termination_out, sync_out, warning_out;
    logic coolant_warning_out, coolant_alarm_out, pulsed_mode_status_out;
    logic [15:0] seed = 16'haf2e; // 44846
    int e_pwr, e_gate, e_rdy, e_emit, e_run, e_end, e_abn, e_ack, n;
    int error_cnt = 0;
    int cmp_count = 0;

    always #20 pclk = ~pclk;

    laser_remote_port #(.DEBOUNCE_CYCLES(2), .SYNC_CYCLES(3)) i_dut (
        .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .run_request_in, .program_start_in,
        .alarm_clear_in, .program_stop_in, .program_number_in, .sync_in,
        .main_power_switch_in, .gate_channel_select_in, .pulsed_mode_enable_in,
        .ready_out, .emitting_out, .internal_mode_out, .anomaly_out, .guide_light_out,
        .analog_power_mode_out, .request_ack_out, .main_power_on_out,
        .program_running_out, .program_ended_out, .abnormal_termination_out, .sync_out,
        .warning_out, .gate_channel_status_out, .coolant_warning_out, .coolant_alarm_out,
        .pulsed_mode_status_out, .unit_address_out);

    machine_controller_model i_ctl (.pclk, .program_running_out, .run_request_in,
        .program_start_in, .alarm_clear_in, .program_stop_in, .program_number_in, .sync_in,
        .main_power_switch_in, .gate_channel_select_in, .pulsed_mode_enable_in);

    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // request held from setup until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task reg_rw(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
        apb(1'b0, a, 32'h0);
        check("reg", v, rd);
        check("slverr", 32'h0, {31'h0, er});
    endtask

    task check_status();
        check("ready", e_rdy, {31'h0, ready_out});
        check("emitting", e_emit, {31'h0, emitting_out});
        check("power", e_pwr, {31'h0, main_power_on_out});
        check("running", e_run, {31'h0, program_running_out});
        check("ended", e_end, {31'h0, program_ended_out});
        check("abnormal", e_abn, {31'h0, abnormal_termination_out});
        check("ack", e_ack, {31'h0, request_ack_out});
        check("gate", e_gate, {28'h0, gate_channel_status_out});
    endtask

    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog sized well above the long alarm-clear hold
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {e_pwr, e_gate, e_rdy, e_emit, e_run, e_end, e_abn, e_ack} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_status();
        // random control and condition words reach the status pins
        for (int i = 0; i < 3; i++) begin
            seed = lfsr_step(seed);
            reg_rw(8'h00, {29'h0, seed[2:0]});
            reg_rw(8'h04, {29'h0, seed[6:4]});
            reg_rw(8'h0c, {28'h0, seed[11:8]});
            check("internal", {31'h0, seed[0]}, {31'h0, internal_mode_out});
            check("guide", {31'h0, seed[1]}, {31'h0, guide_light_out});
            check("analog", {31'h0, seed[2]}, {31'h0, analog_power_mode_out});
            check("anomaly", {31'h0, seed[4]}, {31'h0, anomaly_out});
            check("warning", {31'h0, seed[5]}, {31'h0, warning_out});
            check("cool_warn", {31'h0, seed[6]}, {31'h0, coolant_warning_out});
            check("address", {28'h0, seed[11:8]}, {28'h0, unit_address_out});
        end
        reg_rw(8'h04, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", 32'h1, {31'h0, er});
        $display("test registers done");
        // commands are ignored without the run request
        i_ctl.set_line(6, 1);
        i_ctl.set_line(7, 2);
        check_status();
        i_ctl.set_line(6, 0);
        i_ctl.set_line(7, 0);
        i_ctl.set_line(0, 1);
        e_ack = 1;
        i_ctl.set_line(6, 1);
        e_pwr = 1;
        check_status();
        for (int g = 0; g < 6; g++) begin
            i_ctl.set_line(7, g);
            if (g <= 3) e_gate = g;
            check_status();
        end
        i_ctl.set_line(8, 1);
        check("pulsed", 32'h1, {31'h0, pulsed_mode_status_out});
        i_ctl.set_line(8, 0);
        $display("test port lines done");
        // plain emission enable with number zero, blocked by the coolant alarm
        reg_rw(8'h00, 32'h8);
        e_rdy = 1;
        check_status();
        i_ctl.set_line(1, 1);
        e_emit = 1;
        check_status();
        reg_rw(8'h04, 32'h8);
        check("cool_alarm", 32'h1, {31'h0, coolant_alarm_out});
        check("emit_block", 32'h0, {31'h0, emitting_out});
        reg_rw(8'h04, 32'h0);
        i_ctl.set_line(1, 0);
        e_emit = 0;
        check_status();
        // stored program: wait for sync, sync pulse, normal finish
        seed = lfsr_step(seed);
        num = seed[6:0] | 7'h01;
        i_ctl.set_line(4, num);
        i_ctl.set_line(1, 1);
        {e_run, e_emit} = {2{32'd1}};
        check_status();
        apb(1'b0, 8'h10, 32'h0);
        check("number", {25'h0, num}, {25'h0, rd[20:14]});
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check("state_wait", 32'h2, {30'h0, rd[9:8]});
        i_ctl.set_line(5, 1);
        apb(1'b0, 8'h10, 32'h0);
        check("state_run", 32'h1, {30'h0, rd[9:8]});
        i_ctl.set_line(5, 0);
        apb(1'b1, 8'h08, 32'h8);
        n = 0;
        while (sync_out !== 1'b1 && n < 8) begin
            @(posedge pclk);
            n++;
        end
        check("sync_out", 32'h1, {31'h0, sync_out});
        apb(1'b1, 8'h08, 32'h2);
        repeat (3) @(posedge pclk);
        {e_run, e_emit, e_end} = 96'd1;
        check_status();
        i_ctl.set_line(1, 0);
        e_end = 0;
        check_status();
        // stop input aborts, flag stays until alarm clear
        i_ctl.set_line(1, 1);
        {e_run, e_emit} = {2{32'd1}};
        check_status();
        i_ctl.set_line(3, 1);
        {e_run, e_emit, e_abn} = 96'd1;
        check_status();
        i_ctl.set_line(3, 0);
        i_ctl.set_line(1, 0);
        check_status();
        i_ctl.set_line(1, 1);
        apb(1'b1, 8'h08, 32'h4);
        repeat (2) @(posedge pclk);
        check_status();
        i_ctl.set_line(2, 1);
        e_abn = 0;
        check_status();
        i_ctl.set_line(2, 0);
        $display("test program done");
        tally_and_finish();
    end
endmodule
